// File: core/branch_defs.svh
// constants for the branch sequencing unit
`ifndef BRANCH_DEFS_SVH
`define BRANCH_DEFS_SVH

`define BSU_WORD_W      16
`define BSU_CNT_W       9
`define BSU_OPC_MSB     15
`define BSU_OPC_LSB     11
`define BSU_COND_MSB    10
`define BSU_COND_LSB    8
`define BSU_DISP_MSB    7
`define BSU_SIGN_BIT    15
`define BSU_OPC_JUMP    5'h15
`define BSU_OPC_CBR     5'h16
`define BSU_OPC_LINK    5'h17
`define BSU_ONE         16'h0001
`define BSU_ZERO        16'h0000
`define BSU_CNT_LAST    9'h001
`define BSU_CLK_NS      4
`define BSU_T_TAKEN_NS  1100
`define BSU_T_NTAKEN_NS 800
`define BSU_CYC_TAKEN \
	((`BSU_T_TAKEN_NS + `BSU_CLK_NS - 1) / `BSU_CLK_NS)
`define BSU_CYC_NTAKEN \
	((`BSU_T_NTAKEN_NS + `BSU_CLK_NS - 1) / `BSU_CLK_NS)

`endif

// File: core/branch_pkg.sv
// types for the branch sequencing unit
`include "branch_defs.svh"

package branch_pkg;

	typedef enum logic [2:0] {
		COND_ACC_NONNEG   = 3'h0,
		COND_ACC_NEG      = 3'h1,
		COND_ACC_ZERO     = 3'h2,
		COND_ACC_NONZERO  = 3'h3,
		COND_COUNT_NONNEG = 3'h4,
		COND_COUNT_NEG    = 3'h5,
		COND_INDEX_ZERO   = 3'h6,
		COND_INDEX_NEG    = 3'h7
	} cond_sel_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_EXEC = 2'h1
	} bsu_state_t;

	typedef struct packed {
		bsu_state_t                st;
		logic [`BSU_CNT_W-1:0]     cnt;
		logic [`BSU_WORD_W-1:0]    pc;
		logic [`BSU_WORD_W-1:0]    link;
		logic [`BSU_WORD_W-1:0]    idx;
		logic [`BSU_WORD_W-1:0]    pend_pc;
		logic [`BSU_WORD_W-1:0]    pend_idx;
		logic                      pend_link_we;
		logic                      pend_idx_we;
		logic                      pend_taken;
		logic                      link_we;
		logic                      idx_we;
		logic                      taken;
		logic                      done;
	} bsu_regs_t;

endpackage : branch_pkg

// File: core/branch_sequencing_unit.sv
// branch sequencing unit: jump, jump-and-link and conditional branches
// Summary of operation
// RULE1 - unconditional jump loads effective address into program counter
// RULE2 - jump-and-link saves incremented counter as return, then jumps
// RULE3 - return address points at instruction after the jump-and-link
// RULE4 - instruction bits 8-10 select one of eight branch conditions
// RULE5 - true condition adds displacement to counter, false goes on
// RULE6 - relative reach is 128 back to 127 forward of current location
// RULE7 - software never pairs branches with indirect, base or index modes
// RULE8 - accumulator non-negative branch taken when bit 15 is zero
// RULE9 - accumulator negative branch taken when sign bit is one
// RULE10 - accumulator zero branch taken only when all bits zero
// RULE11 - accumulator nonzero branch taken when any bit is one
// RULE12 - index negative branch taken when index bit 15 is one
// RULE13 - index zero branch taken only when index holds zero
// RULE14 - count non-negative: increment index, branch if bit 15 zero
// RULE15 - count negative: increment index, branch if bit 15 one
// RULE16 - branch time 0.8 us not taken, 1.1 us taken, same for all
// RULE17 - displacement is eight-bit two's complement, sign extended
// RULE18 - effective address for jumps comes from address logic outside
`include "branch_defs.svh"

module branch_sequencing_unit (
	input  wire logic                   sys_clk_i,
	input  wire logic                   rst_b_i,
	input  wire logic                   ce_i,
	input  wire logic                   start_i,
	input  wire logic [`BSU_WORD_W-1:0] instr_i,
	input  wire logic [`BSU_WORD_W-1:0] pc_i,
	input  wire logic [`BSU_WORD_W-1:0] eff_addr_i,
	input  wire logic [`BSU_WORD_W-1:0] acc_i,
	input  wire logic [`BSU_WORD_W-1:0] index_i,
	output logic                        busy_o,
	output logic                        done_o,
	output logic                        taken_o,
	output logic [`BSU_WORD_W-1:0]      pc_o,
	output logic [`BSU_WORD_W-1:0]      link_o,
	output logic                        link_we_o,
	output logic [`BSU_WORD_W-1:0]      index_o,
	output logic                        index_we_o
);
	import branch_pkg::*;

	localparam logic [`BSU_CNT_W-1:0] CYC_TAKEN  =
		`BSU_CNT_W'(`BSU_CYC_TAKEN);
	localparam logic [`BSU_CNT_W-1:0] CYC_NTAKEN =
		`BSU_CNT_W'(`BSU_CYC_NTAKEN);
	// the start cycle is the first cycle of the instruction
	localparam logic [`BSU_CNT_W-1:0] LOAD_TAKEN  = CYC_TAKEN - `BSU_CNT_LAST;
	localparam logic [`BSU_CNT_W-1:0] LOAD_NTAKEN = CYC_NTAKEN - `BSU_CNT_LAST;

	bsu_regs_t              r;
	bsu_regs_t              next_r;
	logic [4:0]             opc;
	cond_sel_t              cond;
	logic [`BSU_WORD_W-1:0] disp_ext;
	logic [`BSU_WORD_W-1:0] idx_inc;
	logic [`BSU_WORD_W-1:0] pc_inc;
	logic                   is_jump;
	logic                   is_link;
	logic                   is_cbr;
	logic                   cond_true;

	// decode of the presented instruction
	assign opc      = instr_i[`BSU_OPC_MSB:`BSU_OPC_LSB];
	assign cond     = cond_sel_t'(instr_i[`BSU_COND_MSB:`BSU_COND_LSB]); // see RULE4
	assign disp_ext = {{(`BSU_WORD_W-`BSU_DISP_MSB-1){instr_i[`BSU_DISP_MSB]}},
		instr_i[`BSU_DISP_MSB:0]}; // see RULE17 see RULE6
	assign idx_inc  = index_i + `BSU_ONE;
	assign pc_inc   = pc_i + `BSU_ONE; // see RULE3
	assign is_jump  = (opc == `BSU_OPC_JUMP);
	assign is_link  = (opc == `BSU_OPC_LINK);
	assign is_cbr   = (opc == `BSU_OPC_CBR);

	// condition evaluation
	always_comb begin
		case (cond)
			COND_ACC_NONNEG:   cond_true = ~acc_i[`BSU_SIGN_BIT]; // see RULE8
			COND_ACC_NEG:      cond_true = acc_i[`BSU_SIGN_BIT]; // see RULE9
			COND_ACC_ZERO:     cond_true = (acc_i == `BSU_ZERO); // see RULE10
			COND_ACC_NONZERO:  cond_true = (acc_i != `BSU_ZERO); // see RULE11
			COND_COUNT_NONNEG: cond_true = ~idx_inc[`BSU_SIGN_BIT]; // see RULE14
			COND_COUNT_NEG:    cond_true = idx_inc[`BSU_SIGN_BIT]; // see RULE15
			COND_INDEX_ZERO:   cond_true = (index_i == `BSU_ZERO); // see RULE13
			COND_INDEX_NEG:    cond_true = index_i[`BSU_SIGN_BIT]; // see RULE12
			default:           cond_true = 1'b0;
		endcase
	end

	// next state
	always_comb begin
		next_r = r;
		if (ce_i) begin
			next_r.done    = 1'b0;
			next_r.link_we = 1'b0;
			next_r.idx_we  = 1'b0;
			case (r.st)
				ST_IDLE: begin
					if (start_i && (is_jump || is_link || is_cbr)) begin
						next_r.st           = ST_EXEC;
						next_r.pend_link_we = is_link;
						next_r.pend_idx_we  = 1'b0;
						next_r.pend_idx     = index_i;
						if (is_cbr) begin
							next_r.pend_taken = cond_true;
							if (cond == COND_COUNT_NONNEG ||
								cond == COND_COUNT_NEG) begin
								next_r.pend_idx_we = 1'b1; // see RULE14 see RULE15
								next_r.pend_idx    = idx_inc;
							end
							if (cond_true) begin
								next_r.pend_pc = pc_i + disp_ext; // see RULE5
								next_r.cnt     = LOAD_TAKEN; // see RULE16
							end else begin
								next_r.pend_pc = pc_inc; // see RULE5
								next_r.cnt     = LOAD_NTAKEN; // see RULE16
							end
						end else begin
							next_r.pend_taken = 1'b1;
							next_r.pend_pc    = eff_addr_i; // see RULE1 see RULE18
							next_r.cnt        = LOAD_TAKEN; // see RULE16
							if (is_link) begin
								next_r.link = pc_inc; // see RULE2 see RULE3
							end
						end
					end
				end
				ST_EXEC: begin
					if (r.cnt == `BSU_CNT_LAST) begin
						next_r.st      = ST_IDLE;
						next_r.done    = 1'b1;
						next_r.pc      = r.pend_pc; // see RULE1 see RULE2
						next_r.taken   = r.pend_taken;
						next_r.link_we = r.pend_link_we; // see RULE2
						next_r.idx_we  = r.pend_idx_we;
						next_r.idx     = r.pend_idx;
					end else begin
						next_r.cnt = r.cnt - `BSU_CNT_LAST;
					end
				end
				default: next_r.st = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign busy_o     = (r.st != ST_IDLE);
	assign done_o     = r.done;
	assign taken_o    = r.taken;
	assign pc_o       = r.pc;
	assign link_o     = r.link;
	assign link_we_o  = r.link_we;
	assign index_o    = r.idx;
	assign index_we_o = r.idx_we;

	// capture of the accepted instruction for the checks below
	logic [4:0]             h_opc;
	logic [2:0]             h_cond;
	logic [7:0]             h_disp;
	logic [`BSU_WORD_W-1:0] h_pc;
	logic [`BSU_WORD_W-1:0] h_ea;
	logic [`BSU_WORD_W-1:0] h_acc;
	logic [`BSU_WORD_W-1:0] h_idx;
	logic [`BSU_CNT_W-1:0]  h_len;
	logic                   h_cbr;

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			h_opc  <= '0;
			h_cond <= '0;
			h_disp <= '0;
			h_pc   <= '0;
			h_ea   <= '0;
			h_acc  <= '0;
			h_idx  <= '0;
			h_len  <= '0;
		end else if (ce_i) begin
			if (r.st == ST_IDLE && next_r.st == ST_EXEC) begin
				h_opc  <= opc;
				h_cond <= instr_i[`BSU_COND_MSB:`BSU_COND_LSB];
				h_disp <= instr_i[`BSU_DISP_MSB:0];
				h_pc   <= pc_i;
				h_ea   <= eff_addr_i;
				h_acc  <= acc_i;
				h_idx  <= index_i;
				h_len  <= '0;
			end else if (busy_o) begin
				h_len <= h_len + `BSU_CNT_LAST;
			end
		end
	end

	assign h_cbr = (h_opc == `BSU_OPC_CBR);

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);

	AST_JUMP_TARGET: assert property ( // see RULE1
		done_o && h_opc == `BSU_OPC_JUMP |-> pc_o == h_ea && !link_we_o)
		else $error("jump did not load effective address");
	AST_LINK_SAVE: assert property ( // see RULE2
		done_o && h_opc == `BSU_OPC_LINK |-> link_we_o && pc_o == h_ea)
		else $error("jump-and-link did not save and jump");
	AST_LINK_NEXT: assert property ( // see RULE3
		done_o && h_opc == `BSU_OPC_LINK |-> link_o == h_pc + `BSU_ONE)
		else $error("return address not the next instruction");
	AST_REL_TARGET: assert property ( // see RULE5
		done_o && h_cbr && taken_o |->
		pc_o == h_pc + {{8{h_disp[7]}}, h_disp})
		else $error("taken branch target wrong");
	AST_FALL_THROUGH: assert property ( // see RULE5
		done_o && h_cbr && !taken_o |-> pc_o == h_pc + `BSU_ONE)
		else $error("untaken branch did not go on in sequence");
	AST_ACC_SIGN: assert property ( // see RULE8
		done_o && h_cbr && h_cond[2:1] == 2'h0 |->
		taken_o == (h_acc[`BSU_SIGN_BIT] == h_cond[0]))
		else $error("accumulator sign test wrong");
	AST_ACC_ZERO: assert property ( // see RULE10
		done_o && h_cbr && h_cond[2:1] == 2'h1 |->
		taken_o == ((h_acc == `BSU_ZERO) != h_cond[0]))
		else $error("accumulator zero test wrong");
	AST_INDEX_TEST: assert property ( // see RULE12
		done_o && h_cbr && h_cond[2:1] == 2'h3 |-> !index_we_o &&
		taken_o == (h_cond[0] ? h_idx[`BSU_SIGN_BIT] : h_idx == `BSU_ZERO))
		else $error("index test wrong");
	AST_COUNT: assert property ( // see RULE14
		done_o && h_cbr && h_cond[2:1] == 2'h2 |-> index_we_o &&
		index_o == h_idx + `BSU_ONE &&
		taken_o == (index_o[`BSU_SIGN_BIT] == h_cond[0]))
		else $error("count branch wrong");
	AST_TIMING: assert property ( // see RULE16
		done_o |-> h_len == (taken_o ? CYC_TAKEN : CYC_NTAKEN) - `BSU_CNT_LAST)
		else $error("branch execution time wrong");
	AST_ACCEPT: assert property ( // see RULE16
		ce_i && !busy_o && start_i && opc == `BSU_OPC_CBR |=>
		busy_o ##1 busy_o)
		else $error("branch not accepted");

	COV_JUMP:   cover property (done_o && h_opc == `BSU_OPC_JUMP);
	COV_LINK:   cover property (done_o && h_opc == `BSU_OPC_LINK);
	COV_TAKEN:  cover property (done_o && h_cbr && taken_o);
	COV_NTAKEN: cover property (done_o && h_cbr && !taken_o);

endmodule : branch_sequencing_unit

// File: bench/reg_file_model.sv
// register file model feeding accumulator and index values
module reg_file_model (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        set_i,
	input  wire logic [15:0] acc_set_i,
	input  wire logic [15:0] idx_set_i,
	input  wire logic        idx_we_i,
	input  wire logic [15:0] idx_wd_i,
	output logic      [15:0] acc_o,
	output logic      [15:0] idx_o
);
	timeunit 1ns;
	timeprecision 100ps;
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			acc_o <= 16'h0000;
			idx_o <= 16'h0000;
		end else if (set_i) begin
			acc_o <= acc_set_i;
			idx_o <= idx_set_i;
		end else if (idx_we_i) begin
			idx_o <= idx_wd_i;
		end
	end
endmodule : reg_file_model

// File: bench/branch_sequencing_unit_tb.sv
// self-checking bench for the branch sequencing unit
`include "branch_defs.svh"
module branch_sequencing_unit_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk, rst_b, ce, start, set;
	logic [15:0] instr, pc, eff, acc_s, idx_s, acc, idx;
	logic        busy, done, taken, link_we, idx_we;
	logic [15:0] pc_o, link, idx_o;
	int          num_errors, n_checks, tno;

	reg_file_model u_rf (.sys_clk_i(clk), .rst_b_i(rst_b), .set_i(set),
		.acc_set_i(acc_s), .idx_set_i(idx_s), .idx_we_i(idx_we),
		.idx_wd_i(idx_o), .acc_o(acc), .idx_o(idx));
	branch_sequencing_unit u_dut (.sys_clk_i(clk), .rst_b_i(rst_b),
		.ce_i(ce), .start_i(start), .instr_i(instr), .pc_i(pc),
		.eff_addr_i(eff), .acc_i(acc), .index_i(idx), .busy_o(busy),
		.done_o(done), .taken_o(taken), .pc_o(pc_o), .link_o(link),
		.link_we_o(link_we), .index_o(idx_o), .index_we_o(idx_we));

	task automatic chk(input string nm, input logic [15:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic run(input logic [15:0] ins, p, ea, a, x);
		logic        tk, cnt;
		logic [15:0] tg, xn;
		int          n, ncyc;
		xn = x + 16'h0001;
		tk = 1'b1;
		tg = ea;
		cnt = ins[15:11] == `BSU_OPC_CBR && ins[10:9] == 2'h2;
		if (ins[15:11] == `BSU_OPC_CBR) begin
			case (ins[10:8])
				3'h0: tk = !a[15];
				3'h1: tk = a[15];
				3'h2: tk = a == 16'h0000;
				3'h3: tk = a != 16'h0000;
				3'h4: tk = !xn[15];
				3'h5: tk = xn[15];
				3'h6: tk = x == 16'h0000;
				default: tk = x[15];
			endcase
			tg = tk ? p + {{8{ins[7]}}, ins[7:0]} : p + 16'h0001;
		end
		@(posedge clk);
		#1;
		set = 1'b1;
		acc_s = a;
		idx_s = x;
		@(posedge clk);
		#1;
		set = 1'b0;
		start = 1'b1;
		instr = ins;
		pc = p;
		eff = ea;
		n = 0;
		// one frozen cycle with clock enable low adds one cycle
		ncyc = (tk ? `BSU_CYC_TAKEN : `BSU_CYC_NTAKEN) + 1;
		do begin
			@(posedge clk);
			#1;
			n++;
			start = (n == 10);
			ce = (n != 20);
		end while (done !== 1'b1 && n < 400);
		chk("cycles", 16'(n), 16'(ncyc));
		chk("taken", 16'(taken), 16'(tk));
		chk("pc", pc_o, tg);
		chk("link_we", 16'(link_we), 16'(ins[15:11] == `BSU_OPC_LINK));
		if (ins[15:11] == `BSU_OPC_LINK) chk("link", link, p + 16'h0001);
		chk("index_we", 16'(idx_we), 16'(cnt));
		if (cnt) chk("index", idx_o, xn);
		@(posedge clk);
		#1;
		chk("done", 16'(done), 16'h0000);
		if (cnt) chk("index_wb", idx, xn);
		$display("test %0d done", tno);
		tno++;
	endtask : run

	task summarize;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : summarize

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		repeat (40000) @(posedge clk);
		num_errors++;
		summarize();
	end

	initial begin
		rst_b = 1'b0;
		ce = 1'b1;
		start = 1'b0;
		set = 1'b0;
		instr = 16'h0000;
		pc = 16'h0000;
		eff = 16'h0000;
		acc_s = 16'h0000;
		idx_s = 16'h0000;
		repeat (12) @(posedge clk);
		#1;
		rst_b = 1'b1;
		void'($urandom(34));
		run({`BSU_OPC_JUMP, 11'h000}, $urandom, $urandom, $urandom, $urandom);
		run({`BSU_OPC_LINK, 11'h000}, 16'hFFFF, $urandom, $urandom, $urandom);
		run({`BSU_OPC_LINK, 11'h000}, $urandom, $urandom, $urandom, $urandom);
		for (int c = 0; c < 8; c++) begin
			// plain condition field and displacement only
			run({`BSU_OPC_CBR, c[2:0], 8'h80}, 16'h0100, 16'h0000,
				16'h0000, 16'hFFFF);
			run({`BSU_OPC_CBR, c[2:0], 8'h7F}, 16'hFFF0, 16'h0000,
				16'h8000, 16'h7FFF);
			run({`BSU_OPC_CBR, c[2:0], 8'($urandom)}, $urandom, $urandom,
				$urandom, $urandom);
		end
		@(posedge clk);
		#1;
		instr = 16'h0000;
		start = 1'b1;
		@(posedge clk);
		#1;
		start = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk("busy_other_opcode", 16'(busy), 16'h0000);
		chk("done_other_opcode", 16'(done), 16'h0000);
		$display("test %0d done", tno);
		summarize();
	end
endmodule : branch_sequencing_unit_tb
